// *** src/pslk_params.svh ***
// Purpose: Constants for the power state link keeper
// Assumes: 100 MHz ref_clk
// Notes on behaviour
// - Four power states, D0 full power down to D3 minimum, D1 and D2 between.
// - In D0 the link is kept active.
// - In D3 the link is kept while wake enable is set and power present.
// - Low power at 10 Mbps: receive normally, transmit pair silent.
// - Low power at 100 Mbps: receive normally, idle stream only, no frames.
// - Link loss in D1 restarts normal auto-negotiation.
// - Link loss in D3 with wake and power: renegotiate or deep power down.
// - In D3 without wake enable or power the link is dropped.
`ifndef PSLK_PARAMS_SVH
`define PSLK_PARAMS_SVH
`define PSLK_ST_D0 2'h0
`define PSLK_ST_D1 2'h1
`define PSLK_ST_D2 2'h2
`define PSLK_ST_D3 2'h3
`define PSLK_ANEG_NS 1000
`define PSLK_ANEG_CYC ((`PSLK_ANEG_NS + 9) / 10)
`define PSLK_HIST_DEPTH 4
`endif

// *** src/pslk_pkg.sv ***
// Purpose: Types for the power state link keeper
// Assumes: Constants in pslk_params.svh
// Notes: Gray coded link states
`include "pslk_params.svh"
package pslk_pkg;
	typedef enum logic [1:0] {
		PSLK_LINK_DOWN = 2'h0,
		PSLK_LINK_NEG  = 2'h1,
		PSLK_LINK_UP   = 2'h3,
		PSLK_LINK_DEEP = 2'h2
	} pslk_link_e;
	typedef enum logic [1:0] {
		PSLK_TX_OFF  = 2'h0,
		PSLK_TX_IDLE = 2'h1,
		PSLK_TX_FULL = 2'h2
	} pslk_tx_e;
endpackage : pslk_pkg

// *** src/pslk_hist_mem.sv ***
// Purpose: Small history memory of past power states
// Assumes: One write per state change
// Notes: Read data registered
`timescale 1ns/1ps
module pslk_hist_mem #(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Write side
	input  wire logic                     wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [1:0]               wrData,
	// Read side
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [1:0]               rdData
);
	logic [1:0] mem [DEPTH];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= 2'h0;
			end
			rdData <= 2'h0;
		end else begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule : pslk_hist_mem

// *** src/pslk_keeper.sv ***
// Purpose: Keeps, drops or renegotiates the link per power state
// Assumes: Inputs synchronous to ref_clk; power state from host
// Notes: deepOnLoss selects the D3 link loss variant
`timescale 1ns/1ps
`include "pslk_params.svh"
module pslk_keeper
	import pslk_pkg::*;
#(
	parameter int ANEG_CYC = `PSLK_ANEG_CYC,
	parameter int HIST_DEPTH = `PSLK_HIST_DEPTH
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Host power control
	input  wire logic [1:0] powerState,
	input  wire logic       wakeEnable,
	input  wire logic       auxPower,
	input  wire logic       deepOnLoss,
	// Line and MAC side
	input  wire logic       linkGood,
	input  wire logic       speed100,
	input  wire logic       macTxValid,
	// Controls
	output logic            linkEnable,
	output logic            anegStart,
	output logic            deepPowerDown,
	output logic            rxEnable,
	output logic            txIdleOnly,
	output logic            txDriveEn,
	output logic            txFrameGate,
	output logic [1:0]      lastState
);
	localparam int HA = $clog2(HIST_DEPTH);
	typedef struct packed {
		pslk_link_e     link;
		logic [15:0]    aneg;
		logic [1:0]     prevPs;
		logic [HA-1:0]  wp;
		logic           start;
		logic           enable;
		logic           deep;
		logic           rx;
		logic           idle;
		logic           drive;
		logic           frames;
	} pslk_state_s;
	pslk_state_s q, d;

	// Whether the link must be held in the given state
	function automatic logic keepLink(input logic [1:0] ps,
		input logic wk, input logic pw);
		unique case (ps)
			`PSLK_ST_D0: keepLink = 1'b1;
			`PSLK_ST_D1, `PSLK_ST_D2: keepLink = 1'b1;
			`PSLK_ST_D3: keepLink = wk & pw;
		endcase
	endfunction : keepLink

	logic keep;
	logic lowPwr;
	logic psChange;
	assign keep = keepLink(powerState, wakeEnable, auxPower);
	assign lowPwr = (powerState != `PSLK_ST_D0);
	assign psChange = (q.prevPs != powerState);

	always_comb begin
		d = q;
		d.start = 1'b0;
		if (psChange) begin
			d.wp = q.wp + 1'b1;
		end
		d.prevPs = powerState;
		unique case (q.link)
			PSLK_LINK_DOWN: begin
				if (keep) begin
					d.link = PSLK_LINK_NEG;
					d.start = 1'b1;
					d.aneg = 16'h0;
				end
			end
			PSLK_LINK_NEG: begin
				if (!keep) begin
					d.link = PSLK_LINK_DOWN;
				end else if (linkGood) begin
					d.link = PSLK_LINK_UP;
				end else if (q.aneg >= 16'(ANEG_CYC - 1)) begin
					d.aneg = 16'h0;
					d.start = 1'b1;
				end else begin
					d.aneg = q.aneg + 16'h1;
				end
			end
			PSLK_LINK_UP: begin
				if (!keep) begin
					d.link = PSLK_LINK_DOWN;
				end else if (!linkGood) begin
					if (powerState == `PSLK_ST_D3 && deepOnLoss) begin
						d.link = PSLK_LINK_DEEP;
					end else begin
						d.link = PSLK_LINK_NEG;
						d.start = 1'b1;
						d.aneg = 16'h0;
					end
				end
			end
			PSLK_LINK_DEEP: begin
				// Leaves deep sleep when the host leaves D3 or wake enable or power drops
				if (powerState != `PSLK_ST_D3 || !keep) begin
					d.link = PSLK_LINK_DOWN;
				end
			end
		endcase
		d.enable = (d.link == PSLK_LINK_NEG) || (d.link == PSLK_LINK_UP);
		d.deep = (d.link == PSLK_LINK_DEEP);
		d.rx = d.enable;
		// Frames only in D0; low power keeps the link passive
		d.frames = d.enable & ~lowPwr;
		d.idle = d.enable & lowPwr & speed100;
		d.drive = d.enable & (~lowPwr | speed100);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	pslk_hist_mem #(.DEPTH(HIST_DEPTH)) uHist (
		.ref_clk (ref_clk),
		.rst     (rst),
		.wrEn    (psChange),
		.wrAddr  (q.wp),
		.wrData  (q.prevPs),
		// Newest entry sits one below the write pointer
		.rdAddr  (q.wp - 1'b1),
		.rdData  (lastState)
	);

	assign linkEnable = q.enable;
	assign anegStart = q.start;
	assign deepPowerDown = q.deep;
	assign rxEnable = q.rx;
	assign txIdleOnly = q.idle;
	assign txDriveEn = q.drive;
	// Live state gate, so the first low power cycle sends no frame
	assign txFrameGate = q.frames & macTxValid & ~lowPwr;

	sequence lossUp;
		q.link == PSLK_LINK_UP && !linkGood && keep;
	endsequence

	sequence negUp;
		q.link == PSLK_LINK_NEG && keep && linkGood;
	endsequence

	AST_D0_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
		powerState == `PSLK_ST_D0 && q.link == PSLK_LINK_DOWN
		|=> q.link == PSLK_LINK_NEG && anegStart)
		else $error("D0 did not bring link up");
	AST_D3_DROP: assert property (@(posedge ref_clk) disable iff (rst)
		powerState == `PSLK_ST_D3 && !(wakeEnable && auxPower)
		|=> !linkEnable)
		else $error("D3 kept link without wake or power");
	AST_D3_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		powerState == `PSLK_ST_D3 && wakeEnable && auxPower
		&& q.link == PSLK_LINK_UP && linkGood |=> linkEnable)
		else $error("D3 link lost with wake and power");
	AST_TX10_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
		$past(lowPwr) && !$past(speed100) |-> !txDriveEn)
		else $error("Transmit driven at 10 Mbps in low power");
	AST_TX100_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
		lowPwr && speed100 && q.enable |-> !txFrameGate)
		else $error("Frame sent in low power");
	AST_D1_RENEG: assert property (@(posedge ref_clk) disable iff (rst)
		lossUp and powerState == `PSLK_ST_D1 |=> anegStart)
		else $error("No renegotiation after D1 loss");
	AST_D3_DEEP: assert property (@(posedge ref_clk) disable iff (rst)
		lossUp and powerState == `PSLK_ST_D3 && deepOnLoss
		|=> deepPowerDown && !linkEnable)
		else $error("No deep power down after D3 loss");
	AST_STATES: assert property (@(posedge ref_clk) disable iff (rst)
		deepPowerDown |-> $past(powerState) == `PSLK_ST_D3)
		else $error("Deep power down outside D3");
	AST_RETRY: assert property (@(posedge ref_clk) disable iff (rst)
		q.link == PSLK_LINK_NEG && keep && !linkGood
		|-> ##[0:1000] anegStart || q.link != PSLK_LINK_NEG)
		else $error("Negotiation not retried");
	// Outputs are registered, so causes are taken one edge back
	AST_D0_FULL: assert property (@(posedge ref_clk) disable iff (rst)
		$past(powerState) == `PSLK_ST_D0 && linkEnable
		|-> txDriveEn && !txIdleOnly)
		else $error("D0 link without full transmit");
	AST_LOW_RX: assert property (@(posedge ref_clk) disable iff (rst)
		$past(lowPwr) && linkEnable
		|-> rxEnable && !txFrameGate)
		else $error("Low power link without plain receive");
	AST_IDLE_100: assert property (@(posedge ref_clk) disable iff (rst)
		$past(lowPwr) && $past(speed100) && linkEnable
		|-> txIdleOnly && txDriveEn)
		else $error("No idle stream at 100 Mbps in low power");
	AST_D1_REUP: assert property (@(posedge ref_clk) disable iff (rst)
		negUp
		|=> linkEnable && !anegStart)
		else $error("Link not taken up after negotiation");
	AST_DEEP_EXIT: assert property (@(posedge ref_clk) disable iff (rst)
		deepPowerDown && powerState != `PSLK_ST_D3
		|=> !deepPowerDown && !linkEnable)
		else $error("Deep power down held outside D3");
	AST_D2_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
		powerState == `PSLK_ST_D2 && q.link == PSLK_LINK_UP && linkGood
		|=> linkEnable)
		else $error("D2 dropped a good link");
	AST_HIST: assert property (@(posedge ref_clk) disable iff (rst)
		$past(psChange, 2)
		|-> lastState == $past(q.prevPs, 2))
		else $error("History lost the previous state");
endmodule : pslk_keeper

// *** bench/pslk_partner.sv ***
// Purpose: Line side partner for the link keeper
// Assumes: Link trains 3 cycles after a start pulse
// Notes: A pulled cable drops the link at the next clock edge, as a real peer would
`timescale 1ns/1ps
module pslk_partner (
	// Clock
	input  wire logic ref_clk,
	// Keeper side
	input  wire logic anegStart,
	input  wire logic linkEnable,
	// Bench control
	input  wire logic cableOk,
	output logic      linkGood
);
	logic [1:0] cnt;
	initial begin
		linkGood = 1'b0;
		cnt = 2'h0;
	end
	always @(posedge ref_clk) begin
		if (!linkEnable || !cableOk) begin
			linkGood <= 1'b0;
			cnt <= 2'h0;
		end else if (anegStart) begin
			cnt <= 2'h1;
		end else if (cnt != 2'h0) begin
			cnt <= cnt + 2'h1;
			linkGood <= linkGood || (cnt == 2'h3);
		end
	end
endmodule : pslk_partner

// *** bench/power_state_link_keeper_tb_top.sv ***
// Purpose: Self-checking bench for the link keeper
// Assumes: Retry interval shortened to 4 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module power_state_link_keeper_tb_top;
	logic ref_clk = 1'b0, rst = 1'b1, wake = 1'b0, pwr = 1'b1, deep = 1'b0;
	logic [1:0] ps = 2'h0, lastState;
	logic cable = 1'b1, spd = 1'b1, txv = 1'b1;
	logic linkGood, linkEnable, anegStart;
	logic deepPowerDown, rxEnable, txIdleOnly, txDriveEn, txFrameGate;
	int n_fail = 0, num_checks = 0, nAneg = 0;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (anegStart === 1'b1) nAneg++;
	pslk_keeper #(.ANEG_CYC(4), .HIST_DEPTH(4)) i_pslk_keeper (
		.ref_clk(ref_clk), .rst(rst), .powerState(ps), .wakeEnable(wake),
		.auxPower(pwr), .deepOnLoss(deep), .linkGood(linkGood),
		.speed100(spd), .macTxValid(txv), .linkEnable(linkEnable),
		.anegStart(anegStart), .deepPowerDown(deepPowerDown),
		.rxEnable(rxEnable), .txIdleOnly(txIdleOnly), .txDriveEn(txDriveEn),
		.txFrameGate(txFrameGate), .lastState(lastState));
	pslk_partner i_pslk_partner (.ref_clk(ref_clk), .anegStart(anegStart),
		.linkEnable(linkEnable), .cableOk(cable), .linkGood(linkGood));
	task automatic chk(string nm, logic [1:0] ex, logic [1:0] got);
		num_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
		end
	endtask : chk
	task automatic go(logic [1:0] p, logic w, logic pw, int n);
		@(negedge ref_clk);
		ps = p;
		wake = w;
		pwr = pw;
		repeat (n) @(negedge ref_clk);
	endtask : go
	task automatic t_d0;
		go(2'h0, 1'b0, 1'b1, 12);
		chk("linkEnable", 1, linkEnable);
		chk("txDriveEn", 1, txDriveEn);
		chk("txFrameGate", 1, txFrameGate);
		txv = 1'b0;
		@(negedge ref_clk);
		chk("txFrameGate idle", 0, txFrameGate);
		txv = 1'b1;
		$display("test d0 done");
	endtask : t_d0
	task automatic t_d3_keep;
		go(2'h3, 1'b1, 1'b1, 12);
		chk("linkEnable", 1, linkEnable);
		chk("rxEnable", 1, rxEnable);
		chk("txIdleOnly", 1, txIdleOnly);
		chk("txFrameGate", 0, txFrameGate);
		chk("lastState", 2'h0, lastState);
		spd = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("txDriveEn", 0, txDriveEn);
		chk("txIdleOnly 10", 0, txIdleOnly);
		chk("rxEnable", 1, rxEnable);
		spd = 1'b1;
		$display("test d3 keep done");
	endtask : t_d3_keep
	task automatic t_d1_loss;
		int n0;
		go(2'h1, 1'b0, 1'b1, 12);
		chk("lastState", 2'h3, lastState);
		n0 = nAneg;
		cable = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk("aneg retry", 1, nAneg > n0);
		cable = 1'b1;
		repeat (12) @(negedge ref_clk);
		chk("linkEnable", 1, linkEnable);
		n0 = nAneg;
		repeat (8) @(negedge ref_clk);
		chk("aneg quiet", 1, nAneg == n0);
		$display("test d1 loss done");
	endtask : t_d1_loss
	task automatic t_d2;
		go(2'h2, 1'b0, 1'b1, 6);
		chk("linkEnable d2", 1, linkEnable);
		chk("txIdleOnly d2", 1, txIdleOnly);
		chk("txFrameGate d2", 0, txFrameGate);
		chk("lastState d2", 2'h1, lastState);
		$display("test d2 done");
	endtask : t_d2
	task automatic t_d3_loss(logic dv);
		int n0;
		deep = dv;
		go(2'h3, 1'b1, 1'b1, 12);
		n0 = nAneg;
		cable = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk("deepPowerDown", dv, deepPowerDown);
		chk("linkEnable", !dv, linkEnable);
		chk("aneg retry", !dv, nAneg > n0);
		cable = 1'b1;
		go(2'h0, 1'b1, 1'b1, 12);
		chk("deep left", 0, deepPowerDown);
		$display("test d3 loss done");
	endtask : t_d3_loss
	task automatic t_d3_drop;
		go(2'h3, 1'b0, 1'b1, 3);
		chk("linkEnable nowake", 0, linkEnable);
		go(2'h3, 1'b1, 1'b1, 12);
		chk("linkEnable rewake", 1, linkEnable);
		go(2'h3, 1'b1, 1'b0, 3);
		chk("linkEnable nopwr", 0, linkEnable);
		chk("txDriveEn", 0, txDriveEn);
		$display("test d3 drop done");
	endtask : t_d3_drop
	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		t_d0();
		t_d3_keep();
		t_d1_loss();
		t_d2();
		t_d3_loss(1'b1);
		t_d3_loss(1'b0);
		t_d3_drop();
		finish_test();
	end
	initial begin
		#20000;
		n_fail++;
		finish_test();
	end
endmodule : power_state_link_keeper_tb_top
